/* hdg_pkg.sv */
// Package with register map, field layout and reset values of the host data pin GPIO block
package hdg_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam int          PIN_N           = 8;
  localparam int          SER_PIN_N       = 6;
  // Data-memory addresses of the two registers
  localparam logic [15:0] ADDR_DIR_CTRL   = 16'h003c;
  localparam logic [15:0] ADDR_PIN_STAT   = 16'h003d;
  // Highest address kept for core registers
  localparam logic [15:0] ADDR_CORE_LAST  = 16'h001f;
  // Field layout of the direction control register
  localparam int          DIR_LSB         = 8;
  localparam int          OUT_LSB         = 0;
  // Field layout of the status register
  localparam int          STAT_PIN_LSB    = 0;
  localparam int          STAT_AVAIL_BIT  = 8;
  // Reset values: all pins inputs, output latch low
  localparam logic [7:0]  DIR_RST         = 8'h00;
  localparam logic [7:0]  OUT_RST         = 8'h00;
  localparam logic [15:0] RDATA_RST       = 16'h0000;
  // Serial pin group split: receive pins low half, transmit pins high half
  localparam int          SER_HALF        = 3;
endpackage

/* hdg_pin_cell.sv */
// One shared pin: picks general-purpose drive or primary-function drive
`timescale 1ns/1ps
module hdg_pin_cell
  import hdg_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic gp_sel,
  input  wire logic gp_dir_out,
  input  wire logic gp_out_val,
  input  wire logic pri_out,
  input  wire logic pri_oe,
  output logic      pin_out_ff,
  output logic      pin_oe_ff
);
  // Registered so the pad sees no glitch when the mode select changes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_out_ff <= 1'b0;
      pin_oe_ff  <= 1'b0;
    end
    else if (gp_sel)
    begin
      pin_out_ff <= gp_out_val;               // [RULE8]
      pin_oe_ff  <= gp_dir_out;               // [RULE8]
    end
    else
    begin
      pin_out_ff <= pri_out;                  // [RULE7]
      pin_oe_ff  <= pri_oe;
    end
  end
endmodule

/* hdg_gpio.sv */
// Top of the host data pin and serial pin general-purpose I/O block
//
// How it works
// [RULE1] Serial pins GPIO only while section in reset
// [RULE2] Host data pins GPIO when port disabled
// [RULE3] Host data pins GPIO in wide mode
// [RULE4] Control register at 3Ch sets pin directions
// [RULE5] Status register at 3Dh shows pin levels
// [RULE6] Addresses 0h-1Fh never answered here
// [RULE7] GPIO only when primary function unused
// [RULE8] Output pins driven from register, else released
`timescale 1ns/1ps
module hdg_gpio
  import hdg_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Data-memory bus
  input  wire logic [ADDR_W-1:0] MEM_ADDR,
  input  wire logic [DATA_W-1:0] MEM_WDATA,
  input  wire logic              MEM_WE,
  input  wire logic              MEM_RE,
  output logic      [DATA_W-1:0] MEM_RDATA,
  output logic                   MEM_RVALID,
  // Host port mode
  input  wire logic              HOST_PORT_ENABLE,
  input  wire logic              HOST_PORT_WIDE_MODE,
  // Host data pins
  input  wire logic [PIN_N-1:0]  HOST_DATA_IN,
  output logic      [PIN_N-1:0]  HOST_DATA_OUT,
  output logic      [PIN_N-1:0]  HOST_DATA_OE,
  input  wire logic [PIN_N-1:0]  HOST_PRI_OUT,
  input  wire logic [PIN_N-1:0]  HOST_PRI_OE,
  // Serial port pins and section resets
  input  wire logic              SER_RX_IN_RESET,
  input  wire logic              SER_TX_IN_RESET,
  input  wire logic [SER_PIN_N-1:0] SER_GP_DIR_OUT,
  input  wire logic [SER_PIN_N-1:0] SER_GP_OUT_VAL,
  input  wire logic [SER_PIN_N-1:0] SER_PRI_OUT,
  input  wire logic [SER_PIN_N-1:0] SER_PRI_OE,
  output logic      [SER_PIN_N-1:0] SER_PIN_OUT,
  output logic      [SER_PIN_N-1:0] SER_PIN_OE,
  output logic                   HOST_GP_ACTIVE
);
  logic [PIN_N-1:0]     dir_ff;
  logic [PIN_N-1:0]     nxt_dir;
  logic [PIN_N-1:0]     out_ff;
  logic [PIN_N-1:0]     nxt_out;
  logic                 host_gp_ff;
  logic                 nxt_host_gp;
  logic                 hit_ctrl;
  logic                 hit_stat;
  logic                 in_core;
  logic                 wr_ctrl;
  logic [DATA_W-1:0]    ctrl_word;
  logic [DATA_W-1:0]    stat_word;
  logic [DATA_W-1:0]    nxt_rdata;
  logic                 nxt_rvalid;
  logic                 ser_rx_gp;
  logic                 ser_tx_gp;
  logic [SER_PIN_N-1:0] ser_gp_sel;

  // Register map
  //   Control word: high byte holds one direction bit per host data pin
  //   (1 drives the pin), low byte the level driven on each output pin.
  //   Status word: low byte holds the pin levels seen in the read cycle,
  //   the next bit says whether the host pins are free for general use;
  //   all other bits read zero and writes to the status word are dropped.
  // The control word stays writable while the host port owns the pins, so
  // software can set up directions before the pins are handed over.

  // Host pins are free when the port is off or runs 16 bits wide
  assign nxt_host_gp = ~HOST_PORT_ENABLE | HOST_PORT_WIDE_MODE;   // [RULE2] [RULE3]

  // Core register range never decodes here even if address bits alias
  assign in_core  = (MEM_ADDR <= ADDR_CORE_LAST);                  // [RULE6]
  assign hit_ctrl = ~in_core & (MEM_ADDR == ADDR_DIR_CTRL);        // [RULE4]
  assign hit_stat = ~in_core & (MEM_ADDR == ADDR_PIN_STAT);        // [RULE5]

  // Only the control word takes writes; a write to the status word is lost
  assign wr_ctrl = MEM_WE & hit_ctrl;                              // [RULE4]

  // Availability tracked in a flop so pins and status switch together
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      host_gp_ff <= 1'b0;
    else
      host_gp_ff <= nxt_host_gp;
  end

  // Next direction bits; held unless the control word is written
  always_comb
  begin
    nxt_dir = dir_ff;
    if (wr_ctrl)
      nxt_dir = MEM_WDATA[DIR_LSB +: PIN_N];                       // [RULE4]
  end

  // Next output levels; taken from the same write as the directions
  always_comb
  begin
    nxt_out = out_ff;
    if (wr_ctrl)
      nxt_out = MEM_WDATA[OUT_LSB +: PIN_N];                       // [RULE8]
  end

  // Direction bits; all pins start as inputs so nothing is driven at power-up
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      dir_ff <= DIR_RST;
    else
      dir_ff <= nxt_dir;
  end

  // Output latch; kept while a pin is an input, so turning it round drives a known level
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      out_ff <= OUT_RST;
    else
      out_ff <= nxt_out;
  end

  // Control word as software wrote it
  always_comb
  begin
    ctrl_word                   = RDATA_RST;
    ctrl_word[DIR_LSB +: PIN_N] = dir_ff;
    ctrl_word[OUT_LSB +: PIN_N] = out_ff;
  end

  // Status word; pin levels come straight from the pads, so a read
  // shows the level of the cycle in which the strobe was sampled
  always_comb
  begin
    stat_word                        = RDATA_RST;
    stat_word[STAT_PIN_LSB +: PIN_N] = HOST_DATA_IN;               // [RULE5]
    stat_word[STAT_AVAIL_BIT]        = host_gp_ff;
  end

  // Read mux; unmapped addresses and idle cycles read zero with no valid
  always_comb
  begin
    nxt_rdata  = RDATA_RST;
    nxt_rvalid = 1'b0;
    if (MEM_RE && hit_ctrl)
    begin
      nxt_rdata  = ctrl_word;                                      // [RULE4]
      nxt_rvalid = 1'b1;
    end
    else if (MEM_RE && hit_stat)
    begin
      nxt_rdata  = stat_word;                                      // [RULE5]
      nxt_rvalid = 1'b1;
    end
  end

  // Read data registered, one cycle after the strobe
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      MEM_RDATA <= RDATA_RST;
    else
      MEM_RDATA <= nxt_rdata;
  end

  // Read valid registered alongside the data so both stand in the same cycle
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      MEM_RVALID <= 1'b0;
    else
      MEM_RVALID <= nxt_rvalid;
  end

  // Mode flag out for the rest of the chip
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      HOST_GP_ACTIVE <= 1'b0;
    else
      HOST_GP_ACTIVE <= host_gp_ff;
  end

  // Each serial half goes to general use only while its own section sits in
  // reset, so a running receiver or transmitter never loses its pins
  assign ser_rx_gp = SER_RX_IN_RESET;                              // [RULE1]
  assign ser_tx_gp = SER_TX_IN_RESET;                              // [RULE1]

  // Receive pins are the low half, transmit pins the high half
  always_comb
  begin
    ser_gp_sel = {SER_PIN_N{1'b0}};
    for (int i = 0; i < SER_PIN_N; i++)
    begin
      if (i < SER_HALF)
        ser_gp_sel[i] = ser_rx_gp;
      else
        ser_gp_sel[i] = ser_tx_gp;
    end
  end

  // One pin cell per host data pin and per serial pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_host
      hdg_pin_cell u_cell (
        .clk        (CLOCK),
        .rst        (RST),
        .gp_sel     (host_gp_ff),                                   // [RULE7]
        .gp_dir_out (dir_ff[gi]),
        .gp_out_val (out_ff[gi]),
        .pri_out    (HOST_PRI_OUT[gi]),
        .pri_oe     (HOST_PRI_OE[gi]),
        .pin_out_ff (HOST_DATA_OUT[gi]),
        .pin_oe_ff  (HOST_DATA_OE[gi])
      );
    end
    for (gi = 0; gi < SER_PIN_N; gi++)
    begin : g_ser
      hdg_pin_cell u_cell (
        .clk        (CLOCK),
        .rst        (RST),
        .gp_sel     (ser_gp_sel[gi]),                               // [RULE1]
        .gp_dir_out (SER_GP_DIR_OUT[gi]),
        .gp_out_val (SER_GP_OUT_VAL[gi]),
        .pri_out    (SER_PRI_OUT[gi]),
        .pri_oe     (SER_PRI_OE[gi]),
        .pin_out_ff (SER_PIN_OUT[gi]),
        .pin_oe_ff  (SER_PIN_OE[gi])
      );
    end
  endgenerate
endmodule

/* hdg_gpio_assertions.sv */
// Port checker for the host data pin GPIO block
`timescale 1ns/1ps
module hdg_gpio_chk
  import hdg_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        MEM_WE,
  input wire logic        MEM_RE,
  input wire logic        MEM_RVALID,
  input wire logic        HOST_GP_ACTIVE,
  input wire logic        HOST_PORT_ENABLE,
  input wire logic        HOST_PORT_WIDE_MODE,
  input wire logic        SER_RX_IN_RESET,
  input wire logic        SER_TX_IN_RESET,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic [7:0]  HOST_DATA_IN,
  input wire logic [7:0]  HOST_DATA_OUT,
  input wire logic [7:0]  HOST_DATA_OE,
  input wire logic [7:0]  HOST_PRI_OUT,
  input wire logic [7:0]  HOST_PRI_OE,
  input wire logic [5:0]  SER_GP_DIR_OUT,
  input wire logic [5:0]  SER_GP_OUT_VAL,
  input wire logic [5:0]  SER_PRI_OUT,
  input wire logic [5:0]  SER_PRI_OE,
  input wire logic [5:0]  SER_PIN_OUT,
  input wire logic [5:0]  SER_PIN_OE
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // Control writes reach the pins two cycles later
  property p_dir; MEM_WE && MEM_ADDR == ADDR_DIR_CTRL ##2 HOST_GP_ACTIVE
    |-> HOST_DATA_OE == $past(MEM_WDATA[15:8], 2); endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");
  property p_out; MEM_WE && MEM_ADDR == ADDR_DIR_CTRL ##2 HOST_GP_ACTIVE
    |-> HOST_DATA_OUT == $past(MEM_WDATA[7:0], 2); endproperty
  a_out: assert property (p_out) else $error("pin drive wrong");
  // Status answers with the pin levels of the request cycle
  property p_stat; MEM_RE && MEM_ADDR == ADDR_PIN_STAT |=> MEM_RVALID
    && MEM_RDATA[7:0] == $past(HOST_DATA_IN) && MEM_RDATA[15:9] == 7'h00; endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  // Control reads are always answered one cycle later
  property p_ctrl_rd; MEM_RE && MEM_ADDR == ADDR_DIR_CTRL |=> MEM_RVALID; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read unanswered");
  property p_core; MEM_RE && MEM_ADDR <= ADDR_CORE_LAST
    |=> !MEM_RVALID && MEM_RDATA == 16'h0000; endproperty
  a_core: assert property (p_core) else $error("core address answered");
  // Mode inputs need three stable samples before the flag is settled
  property p_off; !HOST_PORT_ENABLE [*3] |-> HOST_GP_ACTIVE; endproperty
  a_off: assert property (p_off) else $error("disabled port not GPIO");
  property p_wide; HOST_PORT_WIDE_MODE [*3] |-> HOST_GP_ACTIVE; endproperty
  a_wide: assert property (p_wide) else $error("wide mode not GPIO");
  property p_pri; (HOST_PORT_ENABLE && !HOST_PORT_WIDE_MODE) [*3]
    |-> !HOST_GP_ACTIVE && HOST_DATA_OE == $past(HOST_PRI_OE)
    && HOST_DATA_OUT == $past(HOST_PRI_OUT); endproperty
  a_pri: assert property (p_pri) else $error("primary drive lost");
  // Serial halves follow their own section resets
  property p_ser; SER_TX_IN_RESET [*2]
    |-> SER_PIN_OE[5:3] == $past(SER_GP_DIR_OUT[5:3])
    && SER_PIN_OUT[5:3] == $past(SER_GP_OUT_VAL[5:3]); endproperty
  a_ser: assert property (p_ser) else $error("serial GPIO wrong");
  property p_ser_rx; SER_RX_IN_RESET [*2]
    |-> SER_PIN_OE[2:0] == $past(SER_GP_DIR_OUT[2:0])
    && SER_PIN_OUT[2:0] == $past(SER_GP_OUT_VAL[2:0]); endproperty
  a_ser_rx: assert property (p_ser_rx) else $error("serial receive GPIO wrong");
  property p_ser_pri; (!SER_RX_IN_RESET && !SER_TX_IN_RESET) [*2]
    |-> SER_PIN_OE == $past(SER_PRI_OE) && SER_PIN_OUT == $past(SER_PRI_OUT); endproperty
  a_ser_pri: assert property (p_ser_pri) else $error("serial primary drive lost");
endmodule

bind hdg_gpio hdg_gpio_chk u_chk (
  .CLOCK               (CLOCK),
  .RST                 (RST),
  .MEM_WE              (MEM_WE),
  .MEM_RE              (MEM_RE),
  .MEM_RVALID          (MEM_RVALID),
  .HOST_GP_ACTIVE      (HOST_GP_ACTIVE),
  .HOST_PORT_ENABLE    (HOST_PORT_ENABLE),
  .HOST_PORT_WIDE_MODE (HOST_PORT_WIDE_MODE),
  .SER_RX_IN_RESET     (SER_RX_IN_RESET),
  .SER_TX_IN_RESET     (SER_TX_IN_RESET),
  .MEM_ADDR            (MEM_ADDR),
  .MEM_WDATA           (MEM_WDATA),
  .MEM_RDATA           (MEM_RDATA),
  .HOST_DATA_IN        (HOST_DATA_IN),
  .HOST_DATA_OUT       (HOST_DATA_OUT),
  .HOST_DATA_OE        (HOST_DATA_OE),
  .HOST_PRI_OUT        (HOST_PRI_OUT),
  .HOST_PRI_OE         (HOST_PRI_OE),
  .SER_GP_DIR_OUT      (SER_GP_DIR_OUT),
  .SER_GP_OUT_VAL      (SER_GP_OUT_VAL),
  .SER_PRI_OUT         (SER_PRI_OUT),
  .SER_PRI_OE          (SER_PRI_OE),
  .SER_PIN_OUT         (SER_PIN_OUT),
  .SER_PIN_OE          (SER_PIN_OE)
);

/* hdg_pins_model.sv */
// Board-side model of the shared host data pins
`timescale 1ns/1ps
module hdg_pins_model
(
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] ext,
  output logic      [7:0] pins
);
  // Driven bits read back; released bits follow the board value
  assign pins = (oe & out) | (~oe & ext);
endmodule

/* hdg_gpio_bench.sv */
// Self-checking bench for the host data pin GPIO block
`timescale 1ns/1ps
module hdg_gpio_bench import hdg_pkg::*;;
  logic        CLOCK = 0, RST = 1, MEM_WE = 0, MEM_RE = 0, MEM_RVALID, HOST_GP_ACTIVE, rv, g;
  logic        HOST_PORT_ENABLE = 0, HOST_PORT_WIDE_MODE = 0;
  logic        SER_RX_IN_RESET = 0, SER_TX_IN_RESET = 0;
  logic [15:0] MEM_ADDR = 0, MEM_WDATA = 0, MEM_RDATA, d, rd;
  logic [7:0]  HOST_DATA_IN, HOST_DATA_OUT, HOST_DATA_OE, HOST_PRI_OUT = 0, HOST_PRI_OE = 0;
  logic [7:0]  ext = 0;
  logic [5:0]  SER_GP_DIR_OUT = 0, SER_GP_OUT_VAL = 0, SER_PRI_OUT = 0, SER_PRI_OE = 0;
  logic [5:0]  SER_PIN_OUT, SER_PIN_OE;
  int          mismatches = 0, num_checks = 0;
  hdg_gpio u_dut (
    .CLOCK               (CLOCK),
    .RST                 (RST),
    .MEM_ADDR            (MEM_ADDR),
    .MEM_WDATA           (MEM_WDATA),
    .MEM_WE              (MEM_WE),
    .MEM_RE              (MEM_RE),
    .MEM_RDATA           (MEM_RDATA),
    .MEM_RVALID          (MEM_RVALID),
    .HOST_PORT_ENABLE    (HOST_PORT_ENABLE),
    .HOST_PORT_WIDE_MODE (HOST_PORT_WIDE_MODE),
    .HOST_DATA_IN        (HOST_DATA_IN),
    .HOST_DATA_OUT       (HOST_DATA_OUT),
    .HOST_DATA_OE        (HOST_DATA_OE),
    .HOST_PRI_OUT        (HOST_PRI_OUT),
    .HOST_PRI_OE         (HOST_PRI_OE),
    .SER_RX_IN_RESET     (SER_RX_IN_RESET),
    .SER_TX_IN_RESET     (SER_TX_IN_RESET),
    .SER_GP_DIR_OUT      (SER_GP_DIR_OUT),
    .SER_GP_OUT_VAL      (SER_GP_OUT_VAL),
    .SER_PRI_OUT         (SER_PRI_OUT),
    .SER_PRI_OE          (SER_PRI_OE),
    .SER_PIN_OUT         (SER_PIN_OUT),
    .SER_PIN_OE          (SER_PIN_OE),
    .HOST_GP_ACTIVE      (HOST_GP_ACTIVE)
  );
  hdg_pins_model u_pins (.oe(HOST_DATA_OE), .out(HOST_DATA_OUT), .ext(ext), .pins(HOST_DATA_IN));
  // 20 MHz clock
  initial forever #25 CLOCK = ~CLOCK;
  // Compare and count
  task chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus cycle, answer taken one cycle after the request edge
  task acc(input logic we, re, input logic [15:0] a, w);
    @(posedge CLOCK);
    #1 {MEM_WE, MEM_RE, MEM_ADDR, MEM_WDATA} = {we, re, a, w};
    @(posedge CLOCK);
    #1 {MEM_WE, MEM_RE} = 2'b00;
    rd = MEM_RDATA;
    rv = MEM_RVALID;
  endtask
  // Expected status word from control value, mode and board levels
  function logic [15:0] stat(input logic [15:0] c, input logic [7:0] e, input logic g);
    logic [7:0] oe;
    logic [7:0] o;
    oe = g ? c[15:8] : HOST_PRI_OE;
    o = g ? c[7:0] : HOST_PRI_OUT;
    return {7'h00, g, (oe & o) | (~oe & e)};
  endfunction
  // Expected serial drive {oe, out}; receive pins 0-2, transmit pins 3-5
  function logic [15:0] ser(input logic rx, tx);
    logic [5:0] s;
    s = {tx, tx, tx, rx, rx, rx};
    return {4'h0, (s & SER_GP_DIR_OUT) | (~s & SER_PRI_OE),
            (s & SER_GP_OUT_VAL) | (~s & SER_PRI_OUT)};
  endfunction
  // Verdict
  task finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence; every mode combination is visited, first word is a corner
  initial
  begin
    void'($urandom(65));
    repeat (6) @(posedge CLOCK);
    #1 RST = 0;
    acc(0, 1, ADDR_DIR_CTRL, 0);
    chk(rd, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      d = (i == 0) ? 16'hff5a : 16'($urandom);
      {HOST_PORT_ENABLE, HOST_PORT_WIDE_MODE} = 2'(i);
      g = !HOST_PORT_ENABLE || HOST_PORT_WIDE_MODE;
      {ext, HOST_PRI_OUT, HOST_PRI_OE} = 24'($urandom);
      {SER_TX_IN_RESET, SER_RX_IN_RESET, SER_GP_DIR_OUT, SER_PRI_OE} = 14'($urandom);
      {SER_GP_OUT_VAL, SER_PRI_OUT} = 12'($urandom);
      acc(1, 0, ADDR_DIR_CTRL, d);
      acc(1, 0, ADDR_PIN_STAT, ~d);
      acc(1, 0, 16'($urandom) & ADDR_CORE_LAST, ~d);
      acc(0, 1, ADDR_DIR_CTRL, 0);
      chk(rd, d);
      chk(16'(rv), 16'h0001);
      acc(0, 1, ADDR_PIN_STAT, 0);
      chk(rd, stat(d, ext, g));
      chk({HOST_DATA_OE, HOST_DATA_OUT}, g ? d : {HOST_PRI_OE, HOST_PRI_OUT});
      chk({4'h0, SER_PIN_OE, SER_PIN_OUT}, ser(SER_RX_IN_RESET, SER_TX_IN_RESET));
      acc(0, 1, 16'($urandom) & ADDR_CORE_LAST, 0);
      chk(rd | 16'(rv), 16'h0000);
    end
    // Reset again in mid-run; the control word must come back cleared
    @(posedge CLOCK);
    #1 RST = 1;
    repeat (2) @(posedge CLOCK);
    #1 RST = 0;
    acc(0, 1, ADDR_DIR_CTRL, 0);
    chk(rd, 16'h0000);
    chk(16'(rv), 16'h0001);
    finish_test;
  end
  // Watchdog, well past the expected few hundred cycles
  initial
  begin
    repeat (3000) @(posedge CLOCK);
    mismatches++;
    finish_test;
  end
endmodule
